/* File: hw/cpu_flags_pkg.sv */
package cpu_flags_pkg;

  // Bit positions inside the condition_flags register.
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_I = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_X = 6;
  localparam int FLAG_S = 7;

  // Reset sets the stop-disable bit and both interrupt masks.
  localparam logic [7:0] FLAGS_RESET = 8'hd0;
  localparam logic [15:0] PC_RESET = 16'h0000;

  // Prebyte codes that select opcode pages 1 to 3.
  localparam logic [7:0] PREBYTE_PAGE1 = 8'h18;
  localparam logic [7:0] PREBYTE_PAGE2 = 8'h1a;
  localparam logic [7:0] PREBYTE_PAGE3 = 8'hcd;

  // Direct mode forces this high address byte.
  localparam logic [7:0] DIRECT_PAGE_HIGH = 8'h00;

  typedef enum logic [3:0] {
    ALU_ADD     = 4'h0,
    ALU_ADC     = 4'h1,
    ALU_SUB     = 4'h2,
    ALU_SBC     = 4'h3,
    ALU_CMP     = 4'h4,
    ALU_AND     = 4'h5,
    ALU_OR      = 4'h6,
    ALU_EOR     = 4'h7,
    ALU_LOAD    = 4'h8,
    ALU_ASL     = 4'h9,
    ALU_LSR     = 4'ha,
    ALU_ROL     = 4'hb,
    ALU_ROR     = 4'hc,
    ALU_ASR     = 4'hd,
    ALU_IDX_INC = 4'he,
    ALU_IDX_DEC = 4'hf
  } alu_op_t;

  typedef enum logic [2:0] {
    MODE_INH   = 3'h0,
    MODE_IMM   = 3'h1,
    MODE_DIR   = 3'h2,
    MODE_EXT   = 3'h3,
    MODE_IDX_X = 3'h4,
    MODE_IDX_Y = 3'h5,
    MODE_REL   = 3'h6
  } addr_mode_t;

  typedef enum logic [4:0] {
    S_OPCODE  = 5'b00001,
    S_DECODE  = 5'b00010,
    S_OPERAND = 5'b00100,
    S_ADDR    = 5'b01000,
    S_EXEC    = 5'b10000
  } fetch_state_t;

  typedef struct packed {
    alu_op_t     op;
    logic        wide;
    logic [15:0] a;
    logic [15:0] b;
  } alu_req_t;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
    logic h;
  } alu_flags_t;

  typedef struct packed {
    logic [1:0]  page;
    logic [7:0]  opcode;
    addr_mode_t  mode;
    logic [23:0] operand;
    logic [15:0] ea;
    logic [2:0]  len;
  } insn_t;

endpackage

/* File: hw/flag_alu.sv */
`timescale 1ns/100ps
`default_nettype none
module flag_alu (
  // Operation and incoming carry
  input  wire cpu_flags_pkg::alu_req_t   req_i,
  input  wire logic                      carry_i,
  // Result and raw flags
  output logic [15:0]                    result_o,
  output cpu_flags_pkg::alu_flags_t      flags_o
);
  import cpu_flags_pkg::*;

  logic [15:0] mask;
  logic [15:0] a;
  logic [15:0] bx;
  logic [15:0] r;
  logic [16:0] s;
  logic [3:0]  msb;
  logic        cin;
  logic        co;
  logic        v;
  logic        h;
  logic        arith;
  logic        sub;

  always_comb begin
    mask  = req_i.wide ? 16'hffff : 16'h00ff;
    msb   = req_i.wide ? 4'hf : 4'h7;
    a     = req_i.a & mask;
    bx    = req_i.b & mask;
    cin   = 1'b0;
    co    = carry_i;
    v     = 1'b0;
    h     = 1'b0;
    r     = 16'h0000;
    s     = 17'h00000;
    arith = 1'b0;
    sub   = 1'b0;
    unique case (req_i.op)
      ALU_ADD: arith = 1'b1;
      ALU_ADC: begin
        arith = 1'b1;
        cin   = carry_i;
      end
      ALU_SUB, ALU_CMP: begin
        arith = 1'b1;
        sub   = 1'b1;
        cin   = 1'b1;
      end
      ALU_SBC: begin
        arith = 1'b1;
        sub   = 1'b1;
        cin   = ~carry_i;
      end
      ALU_AND:  r = a & bx;
      ALU_OR:   r = a | bx;
      ALU_EOR:  r = a ^ bx;
      ALU_LOAD: r = bx;
      ALU_ASL: begin
        r  = (a << 1) & mask;
        co = a[msb];
      end
      ALU_LSR: begin
        r  = a >> 1;
        co = a[0];
      end
      ALU_ROL: begin
        r  = ((a << 1) | {15'h0000, carry_i}) & mask;
        co = a[msb];
      end
      ALU_ROR: begin
        r  = (a >> 1) | ({15'h0000, carry_i} << msb);
        co = a[0];
      end
      ALU_ASR: begin
        r  = (a >> 1) | ({15'h0000, a[msb]} << msb);
        co = a[0];
      end
      ALU_IDX_INC: r = req_i.a + 16'h0001;
      ALU_IDX_DEC: r = req_i.a - 16'h0001;
    endcase
    if (arith) begin
      // Subtraction adds the inverted operand; borrow is the inverted carry.
      if (sub) begin
        bx = ~req_i.b & mask;
      end
      s  = {1'b0, a} + {1'b0, bx} + {16'h0000, cin};
      r  = s[15:0] & mask;
      co = req_i.wide ? s[16] : s[8];
      if (sub) begin
        co = ~co;
      end
      v = (a[msb] == bx[msb]) && (r[msb] != a[msb]);
      h = a[4] ^ bx[4] ^ s[4];
    end else if (req_i.op inside {ALU_ASL, ALU_LSR, ALU_ROL, ALU_ROR, ALU_ASR}) begin
      v = r[msb] ^ co;
    end
    result_o  = r;
    flags_o.n = r[msb];
    flags_o.z = (r == 16'h0000);
    flags_o.v = v;
    flags_o.c = co;
    flags_o.h = h;
  end

endmodule
`default_nettype wire

/* File: hw/cpu_flags_and_address_modes.sv */
`timescale 1ns/100ps
`default_nettype none
module cpu_flags_and_address_modes (
  // Clock, reset and clock enable
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  // Internal memory bus, instruction fetch
  output logic [15:0]                   mem_addr_o,
  output logic                          mem_rd_o,
  input  wire logic [7:0]               mem_data_i,
  input  wire logic                     mem_ack_i,
  // Opcode lookup
  output logic [1:0]                    decode_page_o,
  output logic [7:0]                    decode_opcode_o,
  input  wire cpu_flags_pkg::addr_mode_t decode_mode_i,
  input  wire logic [1:0]               decode_count_i,
  // Index registers and branch condition
  input  wire logic [15:0]              first_index_register_i,
  input  wire logic [15:0]              second_index_register_i,
  input  wire logic                     branch_cond_i,
  // Decoded instruction handed to execution
  output cpu_flags_pkg::insn_t          insn_o,
  output logic                          insn_valid_o,
  input  wire logic                     exec_done_i,
  input  wire logic                     pc_load_i,
  input  wire logic [15:0]              pc_value_i,
  output logic [15:0]                   pc_o,
  // ALU request and result
  input  wire logic                     alu_valid_i,
  input  wire cpu_flags_pkg::alu_req_t  alu_req_i,
  output logic [15:0]                   alu_result_o,
  output logic                          alu_store_o,
  input  wire logic                     muldiv_done_i,
  input  wire logic                     muldiv_err_i,
  // Flag loads from accumulator transfer or interrupt return
  input  wire logic                     flags_load_i,
  input  wire logic [7:0]               flags_load_value_i,
  output logic [7:0]                    condition_flags_o,
  // Interrupts
  input  wire logic                     irq_pending_i,
  output logic                          irq_take_o,
  input  wire logic                     nonmaskable_request_pin_n_i,
  output logic                          nonmaskable_request_pin_take_o,
  input  wire logic                     irq_stacked_i,
  input  wire logic                     nonmaskable_request_pin_stacked_i,
  // Low-power halt instruction
  input  wire logic                     stop_exec_i,
  output logic                          stop_enter_o,
  output logic                          stop_skip_o
);
  import cpu_flags_pkg::*;

  fetch_state_t state_reg;
  logic [15:0]  pc_reg;
  logic [1:0]   page_reg;
  logic         prebyte_reg;
  logic [7:0]   opcode_reg;
  addr_mode_t   mode_reg;
  logic [23:0]  operand_reg;
  logic [1:0]   left_reg;
  logic [2:0]   len_reg;
  logic [15:0]  ea_reg;
  logic [15:0]  after_opcode_reg;
  logic [7:0]   flags_reg;
  logic [7:0]   flags_next;
  logic [15:0]  alu_result;
  alu_flags_t   alu_flags;
  logic [15:0]  alu_result_reg;
  logic         alu_store_reg;
  logic         stop_enter_reg;
  logic         stop_skip_reg;
  logic [1:0]   nonmaskable_request_pin_sync_reg;
  logic [1:0]   prebyte_page;
  logic         is_prebyte;
  logic [15:0]  ea_next;
  logic [15:0]  rel_target;

  // Prebyte recognition; a prebyte after a prebyte is an opcode.
  always_comb begin
    prebyte_page = 2'h0;
    is_prebyte   = 1'b0;
    if (!prebyte_reg) begin
      unique case (mem_data_i)
        PREBYTE_PAGE1: begin
          prebyte_page = 2'h1;
          is_prebyte   = 1'b1;
        end
        PREBYTE_PAGE2: begin
          prebyte_page = 2'h2;
          is_prebyte   = 1'b1;
        end
        PREBYTE_PAGE3: begin
          prebyte_page = 2'h3;
          is_prebyte   = 1'b1;
        end
        default: begin
          prebyte_page = 2'h0;
          is_prebyte   = 1'b0;
        end
      endcase
    end
  end

  // Offsets are treated as unsigned for indexed and signed for branches.
  assign rel_target = pc_reg + {{8{operand_reg[7]}}, operand_reg[7:0]};

  always_comb begin
    ea_next = after_opcode_reg;
    unique case (mode_reg)
      MODE_IMM:   ea_next = after_opcode_reg;
      MODE_DIR:   ea_next = {DIRECT_PAGE_HIGH, operand_reg[7:0]};
      MODE_EXT:   ea_next = operand_reg[15:0];
      MODE_IDX_X: ea_next = first_index_register_i + {8'h00, operand_reg[7:0]};
      MODE_IDX_Y: ea_next = second_index_register_i + {8'h00, operand_reg[7:0]};
      MODE_REL:   ea_next = rel_target;
      MODE_INH:   ea_next = after_opcode_reg;
      default:    ea_next = after_opcode_reg;
    endcase
  end

  // Instruction fetch and addressing. Bytes are fetched one at a time, so
  // no alignment is ever needed and the cost is one bus cycle per byte.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg        <= S_OPCODE;
      pc_reg           <= PC_RESET;
      page_reg         <= 2'h0;
      prebyte_reg      <= 1'b0;
      opcode_reg       <= 8'h00;
      mode_reg         <= MODE_INH;
      operand_reg      <= 24'h000000;
      left_reg         <= 2'h0;
      len_reg          <= 3'h0;
      ea_reg           <= 16'h0000;
      after_opcode_reg <= 16'h0000;
    end else if (ce_i) begin
      unique case (state_reg)
        S_OPCODE: begin
          if (mem_ack_i) begin
            pc_reg  <= pc_reg + 16'h0001;
            len_reg <= len_reg + 3'h1;
            if (is_prebyte) begin
              page_reg    <= prebyte_page;
              prebyte_reg <= 1'b1;
            end else begin
              opcode_reg       <= mem_data_i;
              after_opcode_reg <= pc_reg + 16'h0001;
              state_reg        <= S_DECODE;
            end
          end
        end
        S_DECODE: begin
          mode_reg    <= decode_mode_i;
          left_reg    <= decode_count_i;
          operand_reg <= 24'h000000;
          if (decode_count_i == 2'h0) begin
            state_reg <= S_ADDR;
          end else begin
            state_reg <= S_OPERAND;
          end
        end
        S_OPERAND: begin
          if (mem_ack_i) begin
            // The first byte lands highest, so words read big-endian.
            operand_reg <= {operand_reg[15:0], mem_data_i};
            pc_reg      <= pc_reg + 16'h0001;
            len_reg     <= len_reg + 3'h1;
            left_reg    <= left_reg - 2'h1;
            if (left_reg == 2'h1) begin
              state_reg <= S_ADDR;
            end
          end
        end
        S_ADDR: begin
          ea_reg <= ea_next;
          if (mode_reg == MODE_REL && branch_cond_i) begin
            pc_reg <= rel_target;
          end
          state_reg <= S_EXEC;
        end
        S_EXEC: begin
          if (exec_done_i) begin
            if (pc_load_i) begin
              pc_reg <= pc_value_i;
            end
            page_reg    <= 2'h0;
            prebyte_reg <= 1'b0;
            len_reg     <= 3'h0;
            state_reg   <= S_OPCODE;
          end
        end
        default: state_reg <= S_OPCODE;
      endcase
    end
  end

  assign mem_addr_o      = pc_reg;
  assign mem_rd_o        = (state_reg == S_OPCODE) || (state_reg == S_OPERAND);
  assign decode_page_o   = page_reg;
  assign decode_opcode_o = opcode_reg;
  assign insn_valid_o    = (state_reg == S_EXEC);
  assign pc_o            = pc_reg;
  assign insn_o.page     = page_reg;
  assign insn_o.opcode   = opcode_reg;
  assign insn_o.mode     = mode_reg;
  assign insn_o.operand  = operand_reg;
  assign insn_o.ea       = ea_reg;
  assign insn_o.len      = len_reg;

  flag_alu u_flag_alu (
    .req_i    (alu_req_i),
    .carry_i  (flags_reg[FLAG_C]),
    .result_o (alu_result),
    .flags_o  (alu_flags)
  );

  // Flag update. Hardware sets are applied last so a mask set by an
  // interrupt acknowledge wins over a load that clears it in the same cycle.
  always_comb begin
    flags_next = flags_reg;
    if (flags_load_i) begin
      flags_next          = flags_load_value_i;
      flags_next[FLAG_X]  = flags_reg[FLAG_X] & flags_load_value_i[FLAG_X];
    end
    if (alu_valid_i) begin
      unique case (alu_req_i.op)
        ALU_ADD, ALU_ADC: begin
          flags_next[FLAG_N] = alu_flags.n;
          flags_next[FLAG_Z] = alu_flags.z;
          flags_next[FLAG_V] = alu_flags.v;
          flags_next[FLAG_C] = alu_flags.c;
          if (!alu_req_i.wide) begin
            flags_next[FLAG_H] = alu_flags.h;
          end
        end
        ALU_SUB, ALU_SBC, ALU_CMP: begin
          flags_next[FLAG_N] = alu_flags.n;
          flags_next[FLAG_Z] = alu_flags.z;
          flags_next[FLAG_V] = alu_flags.v;
          flags_next[FLAG_C] = alu_flags.c;
        end
        ALU_AND, ALU_OR, ALU_EOR, ALU_LOAD: begin
          flags_next[FLAG_N] = alu_flags.n;
          flags_next[FLAG_Z] = alu_flags.z;
          flags_next[FLAG_V] = 1'b0;
        end
        ALU_ASL, ALU_LSR, ALU_ROL, ALU_ROR, ALU_ASR: begin
          flags_next[FLAG_N] = alu_flags.n;
          flags_next[FLAG_Z] = alu_flags.z;
          flags_next[FLAG_V] = alu_flags.v;
          flags_next[FLAG_C] = alu_flags.c;
        end
        ALU_IDX_INC, ALU_IDX_DEC: begin
          flags_next[FLAG_Z] = alu_flags.z;
        end
      endcase
    end
    if (muldiv_done_i) begin
      flags_next[FLAG_C] = muldiv_err_i;
    end
    if (irq_stacked_i) begin
      flags_next[FLAG_I] = 1'b1;
    end
    if (nonmaskable_request_pin_stacked_i) begin
      flags_next[FLAG_I] = 1'b1;
      flags_next[FLAG_X] = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_reg <= FLAGS_RESET;
    end else if (ce_i) begin
      flags_reg <= flags_next;
    end
  end

  assign condition_flags_o = flags_reg;

  // ALU result; a compare never asks for its difference to be stored.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      alu_result_reg <= 16'h0000;
      alu_store_reg  <= 1'b0;
    end else if (ce_i) begin
      alu_store_reg <= alu_valid_i && (alu_req_i.op != ALU_CMP);
      if (alu_valid_i) begin
        alu_result_reg <= alu_result;
      end
    end
  end

  assign alu_result_o = alu_result_reg;
  assign alu_store_o  = alu_store_reg;

  // The request pin is asynchronous to the core clock.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      nonmaskable_request_pin_sync_reg <= 2'b11;
    end else if (ce_i) begin
      nonmaskable_request_pin_sync_reg <= {nonmaskable_request_pin_sync_reg[0], nonmaskable_request_pin_n_i};
    end
  end

  // Pending requests are only gated here; arbitration sits outside.
  assign irq_take_o  = irq_pending_i && !flags_reg[FLAG_I];
  assign nonmaskable_request_pin_take_o = !nonmaskable_request_pin_sync_reg[1] && !flags_reg[FLAG_X];

  // Halt request resolves in one cycle to either entering stop or skipping.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stop_enter_reg <= 1'b0;
      stop_skip_reg  <= 1'b0;
    end else if (ce_i) begin
      stop_enter_reg <= stop_exec_i && !flags_reg[FLAG_S];
      stop_skip_reg  <= stop_exec_i && flags_reg[FLAG_S];
    end
  end

  assign stop_enter_o = stop_enter_reg;
  assign stop_skip_o  = stop_skip_reg;

endmodule
`default_nettype wire

/* File: tb/cpu_flags_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
module cpu_flags_mem_model (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // Fetch bus
  input  wire logic [15:0] mem_addr_i,
  input  wire logic        mem_rd_i,
  output logic [7:0]       mem_data_o,
  output logic             mem_ack_o,
  // Wait state control
  input  wire logic        slow_i
);
  logic [7:0] mem [0:255];
  logic       wait_reg;

  // Idle data toggles every cycle so that a byte taken without an ack cannot match by luck.
  always @(negedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_ack_o <= 1'b0;
      mem_data_o <= 8'h00;
      wait_reg <= 1'b0;
    end else if (mem_rd_i && !(slow_i && !wait_reg)) begin
      mem_ack_o <= 1'b1;
      mem_data_o <= mem[mem_addr_i[7:0]];
      wait_reg <= 1'b0;
    end else begin
      mem_ack_o <= 1'b0;
      mem_data_o <= ~mem_data_o;
      wait_reg <= mem_rd_i;
    end
  end
endmodule
`default_nettype wire

/* File: tb/cpu_flags_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module cpu_flags_monitor (
  // Clock, reset and enable
  input wire logic                       core_clk_i,
  input wire logic                       rst_i,
  input wire logic                       ce_i,
  // Arithmetic and flag loads
  input wire logic                       alu_valid_i,
  input wire cpu_flags_pkg::alu_req_t    alu_req_i,
  input wire logic [15:0]                alu_result_o,
  input wire logic                       alu_store_o,
  input wire logic                       muldiv_done_i,
  input wire logic                       flags_load_i,
  input wire logic [7:0]                 flags_load_value_i,
  input wire logic [7:0]                 condition_flags_o,
  // Interrupts and halt
  input wire logic                       irq_pending_i,
  input wire logic                       irq_take_o,
  input wire logic                       irq_stacked_i,
  input wire logic                       nonmaskable_request_pin_stacked_i,
  input wire logic                       stop_exec_i,
  input wire logic                       stop_enter_o,
  input wire logic                       stop_skip_o,
  // Decoded instruction
  input wire cpu_flags_pkg::insn_t       insn_o,
  input wire logic                       insn_valid_o
);
  import cpu_flags_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // Same-cycle loads or mask sets would legitimately override the ALU flags.
  logic quiet;
  assign quiet = !flags_load_i && !muldiv_done_i && !irq_stacked_i && !nonmaskable_request_pin_stacked_i;

  reset_flags_a: assert property (
    $fell(rst_i) |-> condition_flags_o == FLAGS_RESET) else $error("Flags wrong after reset");
  irq_gate_a: assert property (
    irq_take_o == (irq_pending_i && !condition_flags_o[FLAG_I])) else $error("Bad irq take");
  pin_mask_set_a: assert property (
    $rose(condition_flags_o[FLAG_X]) |-> $past(nonmaskable_request_pin_stacked_i && ce_i))
    else $error("Pin mask set without acceptance");
  irq_mask_clear_a: assert property (
    $fell(condition_flags_o[FLAG_I]) |-> $past(flags_load_i && ce_i && !flags_load_value_i[4]))
    else $error("Irq mask cleared without load");
  irq_mask_set_a: assert property (
    ce_i && irq_stacked_i |=> condition_flags_o[FLAG_I]) else $error("Irq mask not set");
  both_masks_set_a: assert property (
    ce_i && nonmaskable_request_pin_stacked_i |=> condition_flags_o[FLAG_X] && condition_flags_o[FLAG_I])
    else $error("Masks not set on pin accept");
  stop_reply_a: assert property (
    ce_i && stop_exec_i |=> stop_skip_o == $past(condition_flags_o[FLAG_S])
      && stop_enter_o == !$past(condition_flags_o[FLAG_S])) else $error("Bad halt reply");
  index_z_only_a: assert property (
    ce_i && alu_valid_i && quiet && alu_req_i.op inside {ALU_IDX_INC, ALU_IDX_DEC}
    |=> condition_flags_o[7:3] == $past(condition_flags_o[7:3])
      && condition_flags_o[1:0] == $past(condition_flags_o[1:0])
      && condition_flags_o[FLAG_Z] == (alu_result_o == 16'h0000)) else $error("Index flags");
  cmp_no_store_a: assert property (
    ce_i && alu_valid_i && alu_req_i.op == ALU_CMP |=> !alu_store_o)
    else $error("Compare stored result");
  load_nz_a: assert property (
    ce_i && alu_valid_i && quiet && !alu_req_i.wide && alu_req_i.op == ALU_LOAD
    |=> condition_flags_o[FLAG_N] == alu_result_o[7] && !condition_flags_o[FLAG_V]
      && condition_flags_o[FLAG_Z] == (alu_result_o[7:0] == 8'h00)) else $error("Load flags");
  direct_page_a: assert property (
    insn_valid_o && insn_o.mode == MODE_DIR |-> insn_o.ea == {DIRECT_PAGE_HIGH, insn_o.operand[7:0]})
    else $error("Direct address high byte");
  insn_len_a: assert property (
    insn_valid_o |-> insn_o.len >= 3'd1 && insn_o.len <= 3'd5) else $error("Bad length");

  cover property (insn_valid_o && insn_o.mode == MODE_REL);
  cover property (stop_skip_o);
  cover property (irq_take_o);
endmodule

bind cpu_flags_and_address_modes cpu_flags_monitor u_cpu_flags_monitor (
  .core_clk_i, .rst_i, .ce_i, .alu_valid_i, .alu_req_i, .alu_result_o, .alu_store_o,
  .muldiv_done_i, .flags_load_i, .flags_load_value_i, .condition_flags_o, .irq_pending_i,
  .irq_take_o, .irq_stacked_i, .nonmaskable_request_pin_stacked_i, .stop_exec_i, .stop_enter_o, .stop_skip_o,
  .insn_o, .insn_valid_o);
`default_nettype wire

/* File: tb/cpu_flags_and_address_modes_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module cpu_flags_and_address_modes_bench;
  import cpu_flags_pkg::*;
  logic core_clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, slow_i = 1'b1;
  logic [15:0] mem_addr_o, pc_o, alu_result_o;
  logic mem_rd_o, mem_ack_i, insn_valid_o, alu_store_o, irq_take_o, nonmaskable_request_pin_take_o;
  logic stop_enter_o, stop_skip_o, exec_done_i = 1'b0, alu_valid_i = 1'b0;
  logic [7:0] mem_data_i, decode_opcode_o, condition_flags_o, flags_load_value_i = 8'h00;
  logic [1:0] decode_page_o, decode_count_i;
  logic [4:0] lk;
  addr_mode_t decode_mode_i;
  insn_t insn_o;
  alu_req_t alu_req_i = '0;
  logic muldiv_done_i = 1'b0, muldiv_err_i = 1'b0, flags_load_i = 1'b0;
  logic irq_pending_i = 1'b0, nonmaskable_request_pin_n_i = 1'b1, irq_stacked_i = 1'b0;
  logic nonmaskable_request_pin_stacked_i = 1'b0, stop_exec_i = 1'b0;
  int checks = 0, bad_count = 0;
  logic [7:0] prog [18] = '{8'h96, 8'h40, 8'hb6, 8'h12, 8'h34, PREBYTE_PAGE1, 8'ha6, 8'h10,
    8'ha6, 8'hff, PREBYTE_PAGE3, 8'h83, 8'h01, 8'h02, 8'h03, 8'h01, 8'h20, 8'hfe};

  always #50 core_clk_i = ~core_clk_i;

  cpu_flags_and_address_modes u_cpu_flags_and_address_modes (.core_clk_i, .rst_i, .ce_i,
    .mem_addr_o, .mem_rd_o, .mem_data_i, .mem_ack_i, .decode_page_o, .decode_opcode_o,
    .decode_mode_i, .decode_count_i, .first_index_register_i(16'hfff0),
    .second_index_register_i(16'h2000), .branch_cond_i(1'b1), .insn_o, .insn_valid_o,
    .exec_done_i, .pc_load_i(1'b0), .pc_value_i(16'h0000), .pc_o, .alu_valid_i, .alu_req_i,
    .alu_result_o, .alu_store_o, .muldiv_done_i, .muldiv_err_i, .flags_load_i,
    .flags_load_value_i, .condition_flags_o, .irq_pending_i, .irq_take_o,
    .nonmaskable_request_pin_n_i, .nonmaskable_request_pin_take_o, .irq_stacked_i, .nonmaskable_request_pin_stacked_i, .stop_exec_i,
    .stop_enter_o, .stop_skip_o);

  cpu_flags_mem_model u_cpu_flags_mem_model (.core_clk_i, .rst_i, .mem_addr_i(mem_addr_o),
    .mem_rd_i(mem_rd_o), .mem_data_o(mem_data_i), .mem_ack_o(mem_ack_i), .slow_i);

  // Opcode lookup for the handful of test opcodes: {mode, operand count}.
  always_comb begin
    case ({decode_page_o, decode_opcode_o})
      10'h096: lk = {MODE_DIR, 2'd1};
      10'h0b6: lk = {MODE_EXT, 2'd2};
      10'h0a6: lk = {MODE_IDX_X, 2'd1};
      10'h1a6: lk = {MODE_IDX_Y, 2'd1};
      10'h383: lk = {MODE_IMM, 2'd3};
      10'h020: lk = {MODE_REL, 2'd1};
      default: lk = {MODE_INH, 2'd0};
    endcase
  end
  assign decode_mode_i = addr_mode_t'(lk[4:2]);
  assign decode_count_i = lk[1:0];

  task automatic check(input string what, input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n = 1);
    repeat (n) @(negedge core_clk_i);
  endtask

  task automatic pulse(ref logic sig);
    sig = 1'b1;
    tick();
    sig = 1'b0;
    tick();
  endtask

  task automatic expect_insn(input logic [1:0] page, input addr_mode_t mode,
      input logic [15:0] ea, input logic [2:0] len, input logic [23:0] opnd,
      input logic [1:0] cnt, input logic [15:0] next_pc);
    int n = 0;
    while (insn_valid_o !== 1'b1 && n < 60) begin
      tick();
      n++;
    end
    check("insn page", insn_o.page, page);
    check("insn mode", insn_o.mode, mode);
    check("insn ea", insn_o.ea, ea);
    check("insn len", insn_o.len, len);
    check("insn operand", insn_o.operand & (24'hffffff >> (8 * (3 - cnt))), opnd);
    exec_done_i = 1'b1;
    tick();
    exec_done_i = 1'b0;
    check("next pc", pc_o, next_pc);
    tick();
  endtask

  task automatic alu_step(input alu_op_t op, input logic wide, input logic [15:0] a, b, res,
      input logic [4:0] hnzvc);
    alu_req_i = '{op, wide, a, b};
    alu_valid_i = 1'b1;
    tick();
    alu_valid_i = 1'b0;
    check("alu flags", {condition_flags_o[FLAG_H], condition_flags_o[3:0]}, hnzvc);
    check("alu store", alu_store_o, op != ALU_CMP);
    if (op != ALU_CMP) begin
      check("alu result", alu_result_o, res);
    end
    tick();
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // The sequence needs well under 1000 cycles; three times that means a hang.
  initial begin
    #300000;
    bad_count++;
    close_out();
  end

  initial begin
    for (int i = 0; i < 18; i++) begin
      u_cpu_flags_mem_model.mem[i] = prog[i];
    end
    tick(16);
    rst_i = 1'b0;
    check("reset flags", condition_flags_o, FLAGS_RESET);
    expect_insn(2'd0, MODE_DIR, 16'h0040, 3'd2, 24'h40, 2'd1, 16'd2);
    expect_insn(2'd0, MODE_EXT, 16'h1234, 3'd3, 24'h1234, 2'd2, 16'd5);
    expect_insn(2'd1, MODE_IDX_Y, 16'h2010, 3'd3, 24'h10, 2'd1, 16'd8);
    slow_i = 1'b0;
    expect_insn(2'd0, MODE_IDX_X, 16'h00ef, 3'd2, 24'hff, 2'd1, 16'd10);
    expect_insn(2'd3, MODE_IMM, 16'h000c, 3'd5, 24'h010203, 2'd3, 16'd15);
    expect_insn(2'd0, MODE_INH, 16'h0010, 3'd1, 24'h0, 2'd0, 16'd16);
    expect_insn(2'd0, MODE_REL, 16'h0010, 3'd2, 24'hfe, 2'd1, 16'd16);
    alu_step(ALU_ADD, 1'b0, 16'h000f, 16'h0001, 16'h0010, 5'h10);
    alu_step(ALU_ADD, 1'b0, 16'h0080, 16'h0080, 16'h0000, 5'h07);
    alu_step(ALU_ADC, 1'b0, 16'h0001, 16'h0001, 16'h0003, 5'h00);
    alu_step(ALU_SUB, 1'b0, 16'h0000, 16'h0001, 16'h00ff, 5'h09);
    alu_step(ALU_CMP, 1'b0, 16'h0005, 16'h0005, 16'h0000, 5'h04);
    alu_step(ALU_AND, 1'b0, 16'h00f0, 16'h000f, 16'h0000, 5'h04);
    alu_step(ALU_LOAD, 1'b0, 16'h0080, 16'h0080, 16'h0080, 5'h08);
    alu_step(ALU_ASL, 1'b0, 16'h0081, 16'h0081, 16'h0002, 5'h03);
    alu_step(ALU_IDX_INC, 1'b1, 16'hffff, 16'hffff, 16'h0000, 5'h07);
    alu_step(ALU_IDX_DEC, 1'b1, 16'h0001, 16'h0001, 16'h0000, 5'h07);
    alu_step(ALU_ROL, 1'b0, 16'h0001, 16'h0001, 16'h0003, 5'h00);
    alu_step(ALU_SUB, 1'b1, 16'h8000, 16'h0001, 16'h7fff, 5'h02);
    ce_i = 1'b0;
    muldiv_err_i = 1'b1;
    pulse(muldiv_done_i);
    ce_i = 1'b1;
    check("frozen carry", condition_flags_o[FLAG_C], 1'b0);
    pulse(muldiv_done_i);
    check("muldiv error", condition_flags_o[FLAG_C], 1'b1);
    muldiv_err_i = 1'b0;
    pulse(muldiv_done_i);
    check("muldiv ok", condition_flags_o[FLAG_C], 1'b0);
    irq_pending_i = 1'b1;
    pulse(flags_load_i);
    check("load zero", condition_flags_o, 8'h00);
    check("irq open", irq_take_o, 1'b1);
    flags_load_value_i = 8'hff;
    pulse(flags_load_i);
    check("load ones", condition_flags_o, 8'hbf);
    check("irq held", irq_take_o, 1'b0);
    flags_load_value_i = 8'h00;
    pulse(flags_load_i);
    pulse(irq_stacked_i);
    check("irq accept", condition_flags_o, 8'h10);
    stop_exec_i = 1'b1;
    tick();
    stop_exec_i = 1'b0;
    check("halt enter", {stop_enter_o, stop_skip_o}, 2'b10);
    flags_load_value_i = 8'h80;
    pulse(flags_load_i);
    stop_exec_i = 1'b1;
    tick();
    stop_exec_i = 1'b0;
    check("halt skip", {stop_enter_o, stop_skip_o}, 2'b01);
    nonmaskable_request_pin_n_i = 1'b0;
    tick(4);
    check("pin take", nonmaskable_request_pin_take_o, 1'b1);
    pulse(nonmaskable_request_pin_stacked_i);
    check("pin accept", condition_flags_o, 8'hd0);
    rst_i = 1'b1;
    tick(2);
    rst_i = 1'b0;
    tick(4);
    check("second reset", condition_flags_o, FLAGS_RESET);
    check("pin blocked", nonmaskable_request_pin_take_o, 1'b0);
    check("irq blocked", irq_take_o, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
